// [rtl/wkd_crc16.sv]
// wkd_crc16: byte-serial crc-16 accumulator for one wake-up filter
module wkd_crc16 (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic feed,
  input wire logic [7:0] data,
  output logic [15:0] crc,
  output logic [15:0] crcNxt
);
  logic [15:0] crc_r;
  logic [15:0] base;

  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] v;
    v = c ^ {8'h00, d};
    for (int b = 0; b < 8; b++) begin
      v = v[0] ? ((v >> 1) ^ wkd_pkg::CRC_POLY) : (v >> 1);
    end
    crcByte = v;
  endfunction

  // a frame start restarts the sum even when its own byte is fed
  always_comb begin
    base = start ? wkd_pkg::CRC_INIT : crc_r;
    crcNxt = feed ? crcByte(base, data) : base;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      crc_r <= wkd_pkg::CRC_INIT;
    end else begin
      crc_r <= crcNxt;
    end
  end

  assign crc = crc_r;
endmodule

// [rtl/wkd_pkg.sv]
// wkd_pkg: shared constants and types of the wake-up detector
package wkd_pkg;
  // filter configuration port words, in write order
  localparam logic [2:0] CFG_MASK0 = 3'h0;
  localparam logic [2:0] CFG_MASK3 = 3'h3;
  localparam logic [2:0] CFG_CMD = 3'h4;
  localparam logic [2:0] CFG_OFFS = 3'h5;
  localparam logic [2:0] CFG_CRC01 = 3'h6;
  localparam logic [2:0] CFG_CRC23 = 3'h7;
  localparam logic [2:0] CFG_PTR_RST = 3'h0;
  localparam int unsigned NUM_FILT = 4;
  // field layout
  localparam int unsigned MASK_W = 31;
  localparam logic [10:0] MASK_SPAN = 11'h01F;
  localparam int unsigned CMD_STRIDE = 8;
  localparam int unsigned CMD_EN_BIT = 0;
  localparam int unsigned CMD_MCAST_BIT = 3;
  localparam int unsigned OFFS_W = 8;
  localparam int unsigned CRC_W = 16;
  localparam logic [30:0] MASK_RST = 31'h0000_0000;
  localparam logic [3:0] CMD_RST = 4'h0;
  localparam logic [7:0] OFFS_RST = 8'h00;
  localparam logic [15:0] CRC_RST = 16'h0000;
  // control and status word
  localparam int unsigned CSR_MAGIC_PKT_ENABLE = 1;
  localparam int unsigned CSR_WAKE_FRAME_DETECT_ENABLE = 2;
  localparam int unsigned CSR_MPR = 5;
  localparam int unsigned CSR_WAKE_FRAME_RECEIVED_FLAG = 6;
  localparam int unsigned CSR_IRQEN = 8;
  localparam int unsigned CSR_PMEEN = 9;
  localparam int unsigned CSR_HIT_LSB = 16;
  localparam int unsigned CSR_PTR_LSB = 24;
  // frame layout and magic packet
  localparam int unsigned POS_W = 11;
  localparam logic [10:0] POS_MAX = 11'h7FF;
  localparam logic [10:0] HDR_LEN = 11'h00C;
  localparam logic [10:0] DA_LEN = 11'h006;
  localparam logic [7:0] SYNC_BYTE = 8'hFF;
  localparam logic [2:0] SYNC_LAST = 3'h5;
  localparam logic [2:0] ADDR_LAST = 3'h5;
  localparam logic [4:0] COPY_LAST = 5'h0F;
  // byte-serial crc-16, reflected polynomial
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;

  typedef enum logic [1:0] {
    MS_SYNC = 2'b00,
    MS_ADDR = 2'b01,
    MS_DONE = 2'b11
  } wkd_magic_t;
endpackage

// [rtl/wkd_wake_detect.sv]
// wkd_wake_detect: wake-up frame filters and magic packet detector
// Summary of operation
// - mask bit j feeds byte offset+j; bit31 ignored
// - command bit 3 picks multicast or unicast
// - command bit 0 enables filter; 2:1 reserved
// - 8-bit offset counts from first DA byte
// - expected crc equals computed crc means wake
// - four mask words, then packed command word
// - packed offset word, then two crc words
// - magic enable suppresses normal reception
// - magic detection sets received flag, notifies
// - clearing both magic and wake enables resumes reception
// - magic check on station, broadcast, multicast
// - after addresses, find six FF bytes
// - then sixteen back-to-back station addresses
// - broken run returns to sync search
// - copies count only right after sync
// - wake enable runs filters, sets flag
// - config writes load eight words in order
// - wake needs address type and crc match
// - broadcast wake ignores broadcast blocking
module wkd_wake_detect (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wakeFilterConfigPortWrEn,
  input wire logic [31:0] wakeFilterConfigPortWr,
  input wire logic wakeControlStatusRegWrEn,
  input wire logic [31:0] wakeControlStatusRegWr,
  output logic [31:0] wakeControlStatusRegRd,
  input wire logic [47:0] stationAddr,
  input wire logic rxValid,
  input wire logic rxSof,
  input wire logic rxEof,
  input wire logic [7:0] rxData,
  output logic rxNormalEn,
  output logic irqOut,
  output logic powerEventOutput
);
  // filter configuration
  logic [2:0] cfgPtr_r;
  logic [30:0] mask_r [4];
  logic [3:0] cmd_r [4];
  logic [7:0] offs_r [4];
  logic [15:0] crcExp_r [4];

  // control and status
  logic magicPktEnable_r;
  logic wakeFrameDetectEnable_r;
  logic magicPktReceivedFlag_r;
  logic wakeFrameReceivedFlag_r;
  logic irqNotifyEn_r;
  logic pmeNotifyEn_r;
  logic [3:0] filterHit_r;

  // frame tracking
  logic [10:0] pos_r;
  logic [10:0] pos;
  logic [10:0] posNxt;
  logic daStation_r;
  logic daBcast_r;
  logic daMcast_r;
  logic daStationNxt;
  logic daBcastNxt;
  logic daMcastNxt;

  // magic packet search
  wkd_pkg::wkd_magic_t state_r;
  wkd_pkg::wkd_magic_t stateNxt;
  logic [2:0] ffCnt_r;
  logic [2:0] ffCntNxt;
  logic [2:0] byteIdx_r;
  logic [2:0] byteIdxNxt;
  logic [4:0] copyCnt_r;
  logic [4:0] copyCntNxt;
  logic magicFound;
  logic magicAddrOk;
  logic magicSet;

  // wake filters
  logic [3:0] feed;
  logic [15:0] crcNxt [4];
  logic [3:0] filtMatch;
  logic wakeSet;
  logic ctlWr;

  function automatic logic [7:0] stationByte(input logic [47:0] addr, input logic [2:0] idx);
    stationByte = addr[8 * idx +: 8];
  endfunction

  function automatic logic feedByte(input logic [30:0] mask, input logic [7:0] offs, input logic [10:0] p);
    logic [10:0] rel;
    rel = p - {3'h0, offs};
    feedByte = (p >= {3'h0, offs}) && (rel < wkd_pkg::MASK_SPAN) && mask[rel[4:0]];
  endfunction

  assign ctlWr = wakeControlStatusRegWrEn;

  // ---- filter configuration port ----
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfgPtr_r <= wkd_pkg::CFG_PTR_RST;
    end else if (wakeFilterConfigPortWrEn) begin
      cfgPtr_r <= cfgPtr_r + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 4; i++) begin
        mask_r[i] <= wkd_pkg::MASK_RST;
        cmd_r[i] <= wkd_pkg::CMD_RST;
        offs_r[i] <= wkd_pkg::OFFS_RST;
        crcExp_r[i] <= wkd_pkg::CRC_RST;
      end
    end else if (wakeFilterConfigPortWrEn) begin
      unique case (cfgPtr_r)
        wkd_pkg::CFG_CMD: begin
          for (int i = 0; i < 4; i++) begin
            cmd_r[i] <= wakeFilterConfigPortWr[wkd_pkg::CMD_STRIDE * i +: 4];
          end
        end
        wkd_pkg::CFG_OFFS: begin
          for (int i = 0; i < 4; i++) begin
            offs_r[i] <= wakeFilterConfigPortWr[wkd_pkg::OFFS_W * i +: 8];
          end
        end
        wkd_pkg::CFG_CRC01: begin
          crcExp_r[0] <= wakeFilterConfigPortWr[15:0];
          crcExp_r[1] <= wakeFilterConfigPortWr[31:16];
        end
        wkd_pkg::CFG_CRC23: begin
          crcExp_r[2] <= wakeFilterConfigPortWr[15:0];
          crcExp_r[3] <= wakeFilterConfigPortWr[31:16];
        end
        default: begin
          // words 0..3: byte masks, filter 0 first; top bit dropped
          mask_r[cfgPtr_r[1:0]] <= wakeFilterConfigPortWr[30:0];
        end
      endcase
    end
  end

  // ---- control word: enables and notify selects ----
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      magicPktEnable_r <= 1'b0;
      wakeFrameDetectEnable_r <= 1'b0;
      irqNotifyEn_r <= 1'b0;
      pmeNotifyEn_r <= 1'b0;
    end else if (ctlWr) begin
      magicPktEnable_r <= wakeControlStatusRegWr[wkd_pkg::CSR_MAGIC_PKT_ENABLE];
      wakeFrameDetectEnable_r <= wakeControlStatusRegWr[wkd_pkg::CSR_WAKE_FRAME_DETECT_ENABLE];
      irqNotifyEn_r <= wakeControlStatusRegWr[wkd_pkg::CSR_IRQEN];
      pmeNotifyEn_r <= wakeControlStatusRegWr[wkd_pkg::CSR_PMEEN];
    end
  end

  // ---- frame position and destination address class ----
  always_comb begin
    pos = rxSof ? 11'h000 : pos_r;
    posNxt = (pos == wkd_pkg::POS_MAX) ? pos : pos + 11'h001;
    daStationNxt = daStation_r;
    daBcastNxt = daBcast_r;
    daMcastNxt = daMcast_r;
    if (rxValid && pos < wkd_pkg::DA_LEN) begin
      daStationNxt = (rxSof ? 1'b1 : daStation_r) && (rxData == stationByte(stationAddr, pos[2:0]));
      daBcastNxt = (rxSof ? 1'b1 : daBcast_r) && (rxData == wkd_pkg::SYNC_BYTE);
      if (rxSof) begin
        daMcastNxt = rxData[0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pos_r <= 11'h000;
      daStation_r <= 1'b0;
      daBcast_r <= 1'b0;
      daMcast_r <= 1'b0;
    end else if (rxValid) begin
      pos_r <= posNxt;
      daStation_r <= daStationNxt;
      daBcast_r <= daBcastNxt;
      daMcast_r <= daMcastNxt;
    end
  end

  // ---- wake-up frame filters ----
  for (genvar g = 0; g < 4; g++) begin : gFilt
    assign feed[g] = rxValid && feedByte(mask_r[g], offs_r[g], pos);

    wkd_crc16 uCrc (
      .clk(clk),
      .rst_b(rst_b),
      .start(rxValid && rxSof),
      .feed(feed[g]),
      .data(rxData),
      .crc(),
      .crcNxt(crcNxt[g])
    );
  end

  // evaluated on the last byte, whose own crc contribution is included
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      filtMatch[i] = rxValid && rxEof && wakeFrameDetectEnable_r
        && cmd_r[i][wkd_pkg::CMD_EN_BIT]
        && (cmd_r[i][wkd_pkg::CMD_MCAST_BIT] ? daMcastNxt : daStationNxt)
        && (crcNxt[i] == crcExp_r[i]);
    end
    wakeSet = |filtMatch;
  end

  // ---- magic packet search ----
  always_comb begin
    stateNxt = state_r;
    ffCntNxt = ffCnt_r;
    byteIdxNxt = byteIdx_r;
    copyCntNxt = copyCnt_r;
    magicFound = 1'b0;
    if (rxValid && rxSof) begin
      stateNxt = wkd_pkg::MS_SYNC;
      ffCntNxt = 3'h0;
      byteIdxNxt = 3'h0;
      copyCntNxt = 5'h00;
    end else if (rxValid && magicPktEnable_r && pos >= wkd_pkg::HDR_LEN) begin
      unique case (state_r)
        wkd_pkg::MS_SYNC: begin
          if (rxData == wkd_pkg::SYNC_BYTE) begin
            if (ffCnt_r == wkd_pkg::SYNC_LAST) begin
              stateNxt = wkd_pkg::MS_ADDR;
              ffCntNxt = 3'h0;
              byteIdxNxt = 3'h0;
              copyCntNxt = 5'h00;
            end else begin
              ffCntNxt = ffCnt_r + 3'h1;
            end
          end else begin
            ffCntNxt = 3'h0;
          end
        end
        wkd_pkg::MS_ADDR: begin
          if (rxData == stationByte(stationAddr, byteIdx_r)) begin
            if (byteIdx_r == wkd_pkg::ADDR_LAST) begin
              byteIdxNxt = 3'h0;
              if (copyCnt_r == wkd_pkg::COPY_LAST) begin
                stateNxt = wkd_pkg::MS_DONE;
                magicFound = 1'b1;
              end else begin
                copyCntNxt = copyCnt_r + 5'h01;
              end
            end else begin
              byteIdxNxt = byteIdx_r + 3'h1;
            end
          end else if (rxData == wkd_pkg::SYNC_BYTE && byteIdx_r == 3'h0 && copyCnt_r == 5'h00) begin
            // a sync run longer than six bytes still precedes the copies
            stateNxt = wkd_pkg::MS_ADDR;
          end else begin
            stateNxt = wkd_pkg::MS_SYNC;
            ffCntNxt = (rxData == wkd_pkg::SYNC_BYTE) ? 3'h1 : 3'h0;
            byteIdxNxt = 3'h0;
            copyCntNxt = 5'h00;
          end
        end
        wkd_pkg::MS_DONE: begin
          stateNxt = wkd_pkg::MS_DONE;
        end
        default: begin
          stateNxt = wkd_pkg::MS_SYNC;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= wkd_pkg::MS_SYNC;
      ffCnt_r <= 3'h0;
      byteIdx_r <= 3'h0;
      copyCnt_r <= 5'h00;
    end else begin
      state_r <= stateNxt;
      ffCnt_r <= ffCntNxt;
      byteIdx_r <= byteIdxNxt;
      copyCnt_r <= copyCntNxt;
    end
  end

  // multicast includes broadcast, since its group bit is set
  assign magicAddrOk = daStation_r || daBcast_r || daMcast_r;
  assign magicSet = magicFound && magicAddrOk;

  // ---- sticky flags: a set in the clearing cycle wins ----
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      magicPktReceivedFlag_r <= 1'b0;
    end else if (magicSet) begin
      magicPktReceivedFlag_r <= 1'b1;
    end else if (ctlWr && wakeControlStatusRegWr[wkd_pkg::CSR_MPR]) begin
      magicPktReceivedFlag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wakeFrameReceivedFlag_r <= 1'b0;
    end else if (wakeSet) begin
      wakeFrameReceivedFlag_r <= 1'b1;
    end else if (ctlWr && wakeControlStatusRegWr[wkd_pkg::CSR_WAKE_FRAME_RECEIVED_FLAG]) begin
      wakeFrameReceivedFlag_r <= 1'b0;
    end
  end

  // which filters matched; cleared with the wake flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      filterHit_r <= 4'h0;
    end else if (wakeSet) begin
      filterHit_r <= filterHit_r | filtMatch;
    end else if (ctlWr && wakeControlStatusRegWr[wkd_pkg::CSR_WAKE_FRAME_RECEIVED_FLAG]) begin
      filterHit_r <= 4'h0;
    end
  end

  // ---- outputs ----
  always_comb begin
    wakeControlStatusRegRd = 32'h0000_0000;
    wakeControlStatusRegRd[wkd_pkg::CSR_MAGIC_PKT_ENABLE] = magicPktEnable_r;
    wakeControlStatusRegRd[wkd_pkg::CSR_WAKE_FRAME_DETECT_ENABLE] = wakeFrameDetectEnable_r;
    wakeControlStatusRegRd[wkd_pkg::CSR_MPR] = magicPktReceivedFlag_r;
    wakeControlStatusRegRd[wkd_pkg::CSR_WAKE_FRAME_RECEIVED_FLAG] = wakeFrameReceivedFlag_r;
    wakeControlStatusRegRd[wkd_pkg::CSR_IRQEN] = irqNotifyEn_r;
    wakeControlStatusRegRd[wkd_pkg::CSR_PMEEN] = pmeNotifyEn_r;
    wakeControlStatusRegRd[wkd_pkg::CSR_HIT_LSB +: 4] = filterHit_r;
    wakeControlStatusRegRd[wkd_pkg::CSR_PTR_LSB +: 3] = cfgPtr_r;
  end

  // either detection mode holds off normal reception
  assign rxNormalEn = !(magicPktEnable_r || wakeFrameDetectEnable_r);
  assign irqOut = irqNotifyEn_r && (magicPktReceivedFlag_r || wakeFrameReceivedFlag_r);
  assign powerEventOutput = pmeNotifyEn_r && (magicPktReceivedFlag_r || wakeFrameReceivedFlag_r);
endmodule

// [testbench/wkd_rx_src.sv]
// wkd_rx_src: fabric receive port model streaming one frame byte per beat
module wkd_rx_src (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [8:0] len,
  input wire logic gap,
  input wire logic [7:0] frm [0:255],
  output logic rxValid,
  output logic rxSof,
  output logic rxEof,
  output logic [7:0] rxData,
  output logic busy
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] idx;
  logic hold;
  logic send;
  // gap stalls every other beat
  assign send = busy & (~gap | hold);
  // every frame handed over while idle is forwarded whole to the host side; a start while busy restarts at byte 0
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      idx <= 9'h000;
      hold <= 1'b0;
      rxValid <= 1'b0;
      rxSof <= 1'b0;
      rxEof <= 1'b0;
      rxData <= 8'h00;
    end else begin
      hold <= busy & gap & ~hold;
      rxValid <= send;
      rxSof <= send && idx == 9'h000;
      rxEof <= send && idx == len - 9'h001;
      // idle beats invert the previous data byte, so a run of idle beats toggles it
      rxData <= send ? frm[idx[7:0]] : ~rxData;
      if (start) begin
        busy <= 1'b1;
        idx <= 9'h000;
      end else if (send) begin
        idx <= idx + 9'h001;
        busy <= idx + 9'h001 != len;
      end
    end
  end
endmodule

// [testbench/wkd_wake_detect_checker.sv]
// wkd_wake_detect_checker: port assertions of the wake-up detector
module wkd_wake_detect_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wakeFilterConfigPortWrEn,
  input wire logic [31:0] wakeFilterConfigPortWr,
  input wire logic wakeControlStatusRegWrEn,
  input wire logic [31:0] wakeControlStatusRegWr,
  input wire logic [31:0] wakeControlStatusRegRd,
  input wire logic [47:0] stationAddr,
  input wire logic rxValid,
  input wire logic rxSof,
  input wire logic rxEof,
  input wire logic [7:0] rxData,
  input wire logic rxNormalEn,
  input wire logic irqOut,
  input wire logic powerEventOutput
);
  timeunit 1ns;
  timeprecision 100ps;
  logic we;
  logic [31:0] wd;
  logic [31:0] rd;
  assign we = wakeControlStatusRegWrEn;
  assign wd = wakeControlStatusRegWr;
  assign rd = wakeControlStatusRegRd;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_MAGIC_MODE: assert property (we && wd[1] |=> !rxNormalEn && rd[1])
    else $error("magic enable kept normal reception");
  AST_WAKE_MODE: assert property (we && wd[2] |=> !rxNormalEn && rd[2])
    else $error("wake enable kept normal reception");
  AST_RESUME: assert property (we && !wd[1] && !wd[2] |=> rxNormalEn)
    else $error("normal reception not resumed");
  AST_MAGIC_SET: assert property ($rose(rd[5]) |-> $past(rd[1] && rxValid))
    else $error("magic flag without enable or byte");
  AST_MAGIC_LAST: assert property ($rose(rd[5]) |-> $past(rxData == stationAddr[47:40]))
    else $error("magic flag not after last address byte");
  AST_WAKE_SET: assert property ($rose(rd[6]) |-> $past(rd[2] && rxValid && rxEof))
    else $error("wake flag outside end of frame");
  AST_IRQ: assert property (irqOut == (rd[8] && (rd[5] || rd[6])))
    else $error("irq level wrong");
  AST_PME: assert property (powerEventOutput == (rd[9] && (rd[5] || rd[6])))
    else $error("power event level wrong");
  AST_STICKY: assert property (rd[5] && !(we && wd[5]) |=> rd[5])
    else $error("magic flag dropped");
  AST_CLEAR: assert property (rd[6] && we && wd[6] && !rxValid |=> !rd[6] && rd[19:16] == 4'h0)
    else $error("wake flag not cleared");
  AST_CFG_PTR: assert property (wakeFilterConfigPortWrEn |=> rd[26:24] == $past(rd[26:24]) + 3'h1)
    else $error("config pointer did not advance");
endmodule
bind wkd_wake_detect wkd_wake_detect_checker chk (.clk(clk), .rst_b(rst_b),
  .wakeFilterConfigPortWrEn(wakeFilterConfigPortWrEn), .wakeFilterConfigPortWr(wakeFilterConfigPortWr),
  .wakeControlStatusRegWrEn(wakeControlStatusRegWrEn), .wakeControlStatusRegWr(wakeControlStatusRegWr),
  .wakeControlStatusRegRd(wakeControlStatusRegRd), .stationAddr(stationAddr), .rxValid(rxValid),
  .rxSof(rxSof), .rxEof(rxEof), .rxData(rxData), .rxNormalEn(rxNormalEn), .irqOut(irqOut),
  .powerEventOutput(powerEventOutput));

// [testbench/wkd_wake_detect_tb.sv]
// wkd_wake_detect_tb: self-checking bench of the wake-up detector
module wkd_wake_detect_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [47:0] STA = 48'hBC9A_7856_3412;
  logic clk, rst_b, cfgWe, csWe, start, gap, rxValid, rxSof, rxEof, nrm, irq, power_event_output, busy;
  logic [31:0] cfgWd, csWd, rd;
  logic [7:0] rxData;
  logic [8:0] len;
  logic [7:0] frm [0:255];
  int err_count, checks_done;
  wkd_wake_detect uut (.clk(clk), .rst_b(rst_b), .wakeFilterConfigPortWrEn(cfgWe),
    .wakeFilterConfigPortWr(cfgWd), .wakeControlStatusRegWrEn(csWe), .wakeControlStatusRegWr(csWd),
    .wakeControlStatusRegRd(rd), .stationAddr(STA), .rxValid(rxValid), .rxSof(rxSof), .rxEof(rxEof),
    .rxData(rxData), .rxNormalEn(nrm), .irqOut(irq), .powerEventOutput(power_event_output));
  wkd_rx_src src (.clk(clk), .rst_b(rst_b), .start(start), .len(len), .gap(gap), .frm(frm),
    .rxValid(rxValid), .rxSof(rxSof), .rxEof(rxEof), .rxData(rxData), .busy(busy));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic csw(input logic [31:0] w);
    csWe = 1'b1;
    csWd = w;
    tick(1);
    csWe = 1'b0;
    tick(1);
  endtask
  task automatic frame(input logic [47:0] da, input int n);
    for (int i = 0; i < 256; i++) frm[i] = 8'(i * 5 + 3);
    for (int k = 0; k < 6; k++) frm[k] = da[8*k+:8];
    len = 9'(n);
  endtask
  task automatic magic(input int at, input int copies);
    for (int k = 0; k < 6; k++) frm[at+k] = 8'hFF;
    for (int i = 0; i < copies * 6; i++) frm[at+6+i] = STA[8*(i%6)+:8];
    frm[at+6+copies*6] = 8'h00;
  endtask
  task automatic send(input logic g);
    int n;
    gap = g;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    n = 0;
    while (busy && n < 600) begin
      tick(1);
      n++;
    end
    if (busy) begin
      err_count++;
      $display("wrong value at %0t: frame never ended", $time);
    end
    tick(3);
  endtask
  function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ wkd_pkg::CRC_POLY : c >> 1;
    return c;
  endfunction
  task automatic t_reset();
    chk(rd, 32'h0000_0000, "status");
    chk({29'h0, nrm, irq, power_event_output}, 32'h0000_0004, "outs");
  endtask
  task automatic t_config();
    logic [15:0] c;
    logic [31:0] w [8];
    frame(STA, 64);
    c = crc8(crc8(wkd_pkg::CRC_INIT, frm[14]), frm[16]);
    // masks pick bytes 14 and 16, offsets 14; f0 uc, f1 mc, f2 off, f3 bad crc
    w = '{32'h0000_0005, 32'h0000_0005, 32'h0000_0005, 32'h0000_0005,
      32'h0108_0901, 32'h0E0E_0E0E, {c, c}, {~c, c}};
    for (int i = 0; i < 8; i++) begin
      cfgWe = 1'b1;
      cfgWd = w[i];
      tick(1);
      if (i == 2) chk(32'(rd[26:24]), 32'h0000_0003, "ptr");
    end
    cfgWe = 1'b0;
    chk(32'(rd[26:24]), 32'h0000_0000, "ptr wrap");
  endtask
  task automatic t_wake();
    csw(32'h0000_0104);
    chk({31'h0, nrm}, 32'h0000_0000, "wake mode");
    send(1'b0);
    chk(32'(rd[19:16]), 32'h0000_0001, "uc hits");
    chk({29'h0, rd[6], irq, power_event_output}, 32'h0000_0006, "wake flag");
    csw(32'h0000_0144);
    chk({28'h0, rd[19:16]}, 32'h0000_0000, "hits clr");
    frame(48'hFFFF_FFFF_FFFF, 40);
    frm[15] = 8'h77;
    send(1'b1);
    chk(32'(rd[19:16]), 32'h0000_0002, "bc hits");
    csw(32'h0000_0144);
    frame(48'h0000_005E_0001, 40);
    frm[14] = 8'h00;
    send(1'b0);
    chk(32'(rd[6]), 32'h0000_0000, "bad crc");
    csw(32'h0000_0000);
    chk({31'h0, nrm}, 32'h0000_0001, "resume");
  endtask
  task automatic t_magic();
    csw(32'h0000_0202);
    chk({31'h0, nrm}, 32'h0000_0000, "magic mode");
    frame(STA, 109);
    magic(12, 15);
    send(1'b0);
    chk(32'(rd[5]), 32'h0000_0000, "15 copies");
    frame(48'h0000_005E_0001, 160);
    magic(12, 5);
    magic(49, 16);
    send(1'b1);
    chk({29'h0, rd[5], irq, power_event_output}, 32'h0000_0005, "magic flag");
    csw(32'h0000_0020);
    chk({29'h0, rd[5], nrm, power_event_output}, 32'h0000_0002, "magic off");
    send(1'b0);
    chk(32'(rd[5]), 32'h0000_0000, "no search");
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #40000;
    err_count++;
    print_verdict();
  end
  initial begin
    {rst_b, cfgWe, csWe, start, gap} = 5'h00;
    {cfgWd, csWd, len} = '0;
    frame(STA, 64);
    tick(20);
    rst_b = 1'b1;
    t_reset();
    t_config();
    t_wake();
    t_magic();
    print_verdict();
  end
endmodule
